// File: logic/vbr_regs.sv
// copy/wide-screen payload and picture adjust registers driving the encoder datapath
// What this block does
// [R1] Config low four bits are only the last four copy-generation bits, never wide-screen.
// [R2] Checksum bit high computes the six checksum bits; low sends register bits unchanged.
// [R3] Odd-field enable turns on copy-generation insertion on odd fields, NTSC only.
// [R4] Even-field enable turns on copy-generation insertion on even fields, NTSC only.
// [R5] Wide-screen enable turns on wide-screen output, PAL only.
// [R6] Middle register low six bits: copy payload in NTSC, wide-screen payload in PAL.
// [R7] Middle register top two bits are copy-generation payload only.
// [R8] Low register eight bits: copy payload in NTSC, wide-screen payload in PAL.
// [R9] Contrast code scales luma 0.75 to 1.25, code is (factor-0.75)*128.
// [R10] U colour code scales U 0.75 to 1.25, same coding.
// [R11] V colour code scales V 0.75 to 1.25, same coding.
// [R12] Host writes zero to reserved bits of picture adjust registers.
// [R13] Hue code shifts subcarrier phase one step per unit from 128; 80 hex is none.
// [R14] Hue FF gives largest positive shift, 00 the largest negative.
// [R15] Five-bit brightness adds 0 to 7.5 IRE pedestal, 18 steps, both standards.
// [R16] Four-bit sharpness picks luma response; 12 is +4 dB, 0 is -4 dB, 6 normal.
// [R17] Hue offset applies only while hue adjust enable is high.
// [R18] Pedestal added only while brightness enable is high.
// [R19] Every register is read/write and reads back the value last written.
module vbr_regs (
  input  wire logic                ref_clk,          // 20 MHz pixel clock
  input  wire logic                rstn,             // asynchronous reset, active low
  input  wire logic [7:0]          regAddr,          // register subaddress from the serial interface
  input  wire logic [7:0]          regWrData,        // write data
  input  wire logic                regWr,            // one-cycle write strobe
  input  wire logic                regRd,            // one-cycle read strobe
  output logic      [7:0]          regRdData,        // read data, valid the cycle after regRd
  input  wire logic                palMode,          // encoder standard: high PAL, low NTSC
  input  wire logic                hueAdjustEnable,  // hue adjust enable from the mode register
  input  wire logic                brightnessEnable, // brightness enable from the mode register
  output vbr_pkg::vbr_vbi_s        vbiOut,           // vbi payload and line enables
  output vbr_pkg::vbr_picture_s    pictureOut        // picture adjust settings for the datapath
);

  logic       rstMeta;
  logic       rstSync;
  logic [7:0] copyControlConfig;
  logic [7:0] copyControlPayloadMid;
  logic [7:0] copyControlPayloadLow;
  logic [7:0] lumaContrastScale;
  logic [7:0] uColourScale;
  logic [7:0] vColourScale;
  logic [7:0] huePhaseOffset;
  logic [7:0] brightnessPedestal;
  logic [7:0] lumaSharpnessSelect;
  logic [19:0] rawCgms;
  logic [19:0] cgmsFinished;
  logic [7:0]  next_regRdData;

  // reset release is synchronised so all flops leave reset on the same edge
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstSync);

  // 0.75 + code/128 expressed as gain*128, so the datapath multiplies and shifts by 7
  function automatic logic [7:0] scaleGain(input logic [7:0] regValue);
    return vbr_pkg::GAIN_BASE + {2'b00, regValue[5:0]};
  endfunction : scaleGain

  // true for the subaddresses of this group; any other subaddress reads as zero
  function automatic logic isMapped(input logic [7:0] addr);
    case (addr)
      vbr_pkg::ADDR_COPY_CONFIG,
      vbr_pkg::ADDR_PAYLOAD_MID,
      vbr_pkg::ADDR_PAYLOAD_LOW,
      vbr_pkg::ADDR_CONTRAST,
      vbr_pkg::ADDR_U_COLOUR,
      vbr_pkg::ADDR_V_COLOUR,
      vbr_pkg::ADDR_HUE,
      vbr_pkg::ADDR_BRIGHTNESS,
      vbr_pkg::ADDR_SHARPNESS: return 1'b1;
      default:                 return 1'b0;
    endcase
  endfunction : isMapped

  // reserved bits are stored as written so readback is exact; the datapath ignores them
  always_ff @(posedge ref_clk or negedge rstSync) begin
    if (!rstSync) begin
      copyControlConfig     <= vbr_pkg::RST_COPY_CONFIG;
      copyControlPayloadMid <= vbr_pkg::RST_PAYLOAD_MID;
      copyControlPayloadLow <= vbr_pkg::RST_PAYLOAD_LOW;
    end else if (regWr) begin
      case (regAddr)
        vbr_pkg::ADDR_COPY_CONFIG: begin
          copyControlConfig <= regWrData;  // see [R19]
        end
        vbr_pkg::ADDR_PAYLOAD_MID: begin
          copyControlPayloadMid <= regWrData;  // see [R19]
        end
        vbr_pkg::ADDR_PAYLOAD_LOW: begin
          copyControlPayloadLow <= regWrData;  // see [R19]
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rstSync) begin
    if (!rstSync) begin
      lumaContrastScale   <= vbr_pkg::RST_SCALE;
      uColourScale        <= vbr_pkg::RST_SCALE;
      vColourScale        <= vbr_pkg::RST_SCALE;
      huePhaseOffset      <= vbr_pkg::RST_HUE;
      brightnessPedestal  <= vbr_pkg::RST_BRIGHTNESS;
      lumaSharpnessSelect <= vbr_pkg::RST_SHARPNESS;
    end else if (regWr) begin
      case (regAddr)
        vbr_pkg::ADDR_CONTRAST: begin
          lumaContrastScale <= regWrData;  // see [R19]
        end
        vbr_pkg::ADDR_U_COLOUR: begin
          uColourScale <= regWrData;  // see [R19]
        end
        vbr_pkg::ADDR_V_COLOUR: begin
          vColourScale <= regWrData;  // see [R19]
        end
        vbr_pkg::ADDR_HUE: begin
          huePhaseOffset <= regWrData;  // see [R19]
        end
        vbr_pkg::ADDR_BRIGHTNESS: begin
          brightnessPedestal <= regWrData;  // see [R19]
        end
        vbr_pkg::ADDR_SHARPNESS: begin
          lumaSharpnessSelect <= regWrData;  // see [R19]
        end
        default: begin
        end
      endcase
    end
  end

  always_comb begin
    case (regAddr)
      vbr_pkg::ADDR_COPY_CONFIG: next_regRdData = copyControlConfig;
      vbr_pkg::ADDR_PAYLOAD_MID: next_regRdData = copyControlPayloadMid;
      vbr_pkg::ADDR_PAYLOAD_LOW: next_regRdData = copyControlPayloadLow;
      vbr_pkg::ADDR_CONTRAST:    next_regRdData = lumaContrastScale;
      vbr_pkg::ADDR_U_COLOUR:    next_regRdData = uColourScale;
      vbr_pkg::ADDR_V_COLOUR:    next_regRdData = vColourScale;
      vbr_pkg::ADDR_HUE:         next_regRdData = huePhaseOffset;
      vbr_pkg::ADDR_BRIGHTNESS:  next_regRdData = brightnessPedestal;
      vbr_pkg::ADDR_SHARPNESS:   next_regRdData = lumaSharpnessSelect;
      default:                   next_regRdData = vbr_pkg::UNMAPPED_READ;
    endcase
  end

  // read data holds until the next read strobe
  always_ff @(posedge ref_clk or negedge rstSync) begin
    if (!rstSync) begin
      regRdData <= vbr_pkg::RST_READ_DATA;
    end else if (regRd) begin
      regRdData <= next_regRdData;  // see [R19]
    end
  end

  // copy payload order: C0..C7 low, C8..C15 mid, C16..C19 config tail
  assign rawCgms = {copyControlConfig[vbr_pkg::CFG_TAIL_MSB:0],  // see [R1]
                    copyControlPayloadMid,                       // see [R6] [R7]
                    copyControlPayloadLow};                      // see [R8]

  vbr_crc_gen u_crc (
    .ref_clk    (ref_clk),
    .rstn       (rstSync),
    .rawPayload (rawCgms),
    .autoCrc    (copyControlConfig[vbr_pkg::CFG_CHECKSUM_AUTO]),
    .payload    (cgmsFinished)
  );

  // enables are gated by the standard so a stale bit cannot insert lines in the wrong mode
  always_ff @(posedge ref_clk or negedge rstSync) begin
    if (!rstSync) begin
      vbiOut.oddFieldEnable   <= 1'b0;
      vbiOut.evenFieldEnable  <= 1'b0;
      vbiOut.wideScreenEnable <= 1'b0;
      vbiOut.wssPayload       <= 14'h0000;
    end else begin
      vbiOut.oddFieldEnable   <= copyControlConfig[vbr_pkg::CFG_ODD_FIELD] & ~palMode;   // see [R3]
      vbiOut.evenFieldEnable  <= copyControlConfig[vbr_pkg::CFG_EVEN_FIELD] & ~palMode;  // see [R4]
      vbiOut.wideScreenEnable <= copyControlConfig[vbr_pkg::CFG_WIDE_SCREEN] & palMode;  // see [R5]
      // W0..W7 from low, W8..W13 from mid; config tail never feeds wide-screen
      vbiOut.wssPayload <= {copyControlPayloadMid[vbr_pkg::SHARED_MID_MSB:0],  // see [R6] [R1]
                            copyControlPayloadLow};                            // see [R8]
    end
  end

  assign vbiOut.cgmsPayload = cgmsFinished;

  always_ff @(posedge ref_clk or negedge rstSync) begin
    if (!rstSync) begin
      pictureOut.lumaGain <= scaleGain(vbr_pkg::RST_SCALE);
      pictureOut.uGain    <= scaleGain(vbr_pkg::RST_SCALE);
      pictureOut.vGain    <= scaleGain(vbr_pkg::RST_SCALE);
    end else begin
      pictureOut.lumaGain <= scaleGain(lumaContrastScale);  // see [R9]
      pictureOut.uGain    <= scaleGain(uColourScale);       // see [R10]
      pictureOut.vGain    <= scaleGain(vColourScale);       // see [R11]
    end
  end

  // hue is code minus 128, two's complement: FF is +127 steps, 00 is -128 steps
  always_ff @(posedge ref_clk or negedge rstSync) begin
    if (!rstSync) begin
      pictureOut.huePhase <= 8'sh00;
    end else if (hueAdjustEnable) begin
      pictureOut.huePhase <= $signed(huePhaseOffset - vbr_pkg::HUE_CENTRE);  // see [R13] [R14] [R17]
    end else begin
      pictureOut.huePhase <= 8'sh00;  // see [R17]
    end
  end

  // out-of-range codes saturate rather than wrap, since the top of each range is the documented limit
  always_ff @(posedge ref_clk or negedge rstSync) begin
    if (!rstSync) begin
      pictureOut.pedestal  <= 5'h00;
      pictureOut.sharpness <= vbr_pkg::RST_SHARPNESS[3:0];
    end else begin
      if (!brightnessEnable) begin
        pictureOut.pedestal <= 5'h00;  // see [R18]
      end else if (brightnessPedestal[4:0] > vbr_pkg::PEDESTAL_MAX) begin
        pictureOut.pedestal <= vbr_pkg::PEDESTAL_MAX;  // see [R15]
      end else begin
        pictureOut.pedestal <= brightnessPedestal[4:0];  // see [R15]
      end
      if (lumaSharpnessSelect[3:0] > vbr_pkg::SHARPNESS_MAX) begin
        pictureOut.sharpness <= vbr_pkg::SHARPNESS_MAX;  // see [R16]
      end else begin
        pictureOut.sharpness <= lumaSharpnessSelect[3:0];  // see [R16]
      end
    end
  end

  copy_generation_info_tail_a: assert property (1'b1 |=> vbiOut.cgmsPayload[19:16] == $past(copyControlConfig[3:0])  // see [R1]
                                 || $past(copyControlConfig[vbr_pkg::CFG_CHECKSUM_AUTO]))
    else $error("copy payload tail not from config register");
  odd_field_en_a: assert property (vbiOut.oddFieldEnable |-> $past(copyControlConfig[5]) && !$past(palMode))  // see [R3]
    else $error("odd field insertion outside NTSC or unrequested");
  even_field_en_a: assert property (copyControlConfig[6] && !palMode |=> vbiOut.evenFieldEnable)  // see [R4]
    else $error("even field insertion missing in NTSC");
  wide_screen_en_a: assert property (vbiOut.wideScreenEnable |-> $past(palMode) && $past(copyControlConfig[7]))  // see [R5]
    else $error("wide-screen enabled outside PAL");
  wss_payload_a: assert property (1'b1 |=> vbiOut.wssPayload == $past({copyControlPayloadMid[5:0],  // see [R6]
                                                                       copyControlPayloadLow}))
    else $error("wide-screen payload misplaced");
  copy_generation_info_mid_a: assert property (1'b1 |=> vbiOut.cgmsPayload[13:0] == $past(rawCgms[13:0]))  // see [R6] [R8]
    else $error("copy payload data bits misplaced");
  manual_top_a: assert property (!copyControlConfig[4] |=> vbiOut.cgmsPayload[15:8] == $past(copyControlPayloadMid))  // see [R7]
    else $error("middle register top bits lost from copy payload");
  luma_gain_a: assert property (1'b1 |=> pictureOut.lumaGain == 8'h60 + $past({2'b00, lumaContrastScale[5:0]}))  // see [R9]
    else $error("contrast gain wrong");
  colour_gain_a: assert property (1'b1 |=> pictureOut.uGain == 8'h60 + $past({2'b00, uColourScale[5:0]})  // see [R10] [R11]
                                   && pictureOut.vGain == 8'h60 + $past({2'b00, vColourScale[5:0]}))
    else $error("colour gain wrong");
  hue_limits_a: assert property (hueAdjustEnable && huePhaseOffset == 8'hFF |=> pictureOut.huePhase == 8'sh7F)  // see [R14]
    else $error("hue upper limit wrong");
  hue_off_a: assert property (!hueAdjustEnable |=> pictureOut.huePhase == 8'sh00)  // see [R17]
    else $error("hue applied while disabled");
  hue_centre_a: assert property (hueAdjustEnable && huePhaseOffset == 8'h80 |=> pictureOut.huePhase == 8'sh00)  // see [R13]
    else $error("hue centre not zero shift");
  pedestal_a: assert property (brightnessEnable |=> pictureOut.pedestal <= 5'h12)  // see [R15]
    else $error("pedestal above 7.5 IRE code");
  pedestal_off_a: assert property (!brightnessEnable |=> pictureOut.pedestal == 5'h00)  // see [R18]
    else $error("pedestal added while disabled");
  sharpness_a: assert property (lumaSharpnessSelect[3:0] <= 4'hC |=> pictureOut.sharpness == $past(lumaSharpnessSelect[3:0]))  // see [R16]
    else $error("sharpness code not passed");
  readback_a: assert property (regWr ##1 (regRd && regAddr == $past(regAddr) && !regWr)  // see [R19]
                               |=> regRdData == ($past(isMapped(regAddr)) ? $past(regWrData, 2) : 8'h00))
    else $error("read does not return last write");
  unmapped_read_a: assert property (regRd && !isMapped(regAddr) |=> regRdData == 8'h00)  // see [R19]
    else $error("unmapped read not zero");
  contrast_write_a: assert property (regWr && regAddr == vbr_pkg::ADDR_CONTRAST  // see [R19]
                                     |=> lumaContrastScale == $past(regWrData))
    else $error("contrast write not stored");
  hue_lower_a: assert property (hueAdjustEnable && huePhaseOffset == 8'h00 |=> pictureOut.huePhase == -8'sd128)  // see [R14]
    else $error("hue lower limit wrong");
  pedestal_sat_a: assert property (brightnessEnable && brightnessPedestal[4:0] > 5'h12  // see [R15]
                                   |=> pictureOut.pedestal == 5'h12)
    else $error("pedestal not saturated");
  sharpness_sat_a: assert property (lumaSharpnessSelect[3:0] > 4'hC |=> pictureOut.sharpness == 4'hC)  // see [R16]
    else $error("sharpness not saturated");
  pal_no_copy_generation_info_a: assert property (palMode |=> !vbiOut.oddFieldEnable && !vbiOut.evenFieldEnable)  // see [R3] [R4]
    else $error("copy insertion enabled in PAL");
  ntsc_no_wss_a: assert property (!palMode |=> !vbiOut.wideScreenEnable)  // see [R5]
    else $error("wide-screen enabled in NTSC");
  wss_ignores_tail_a: assert property (1'b1 |=> vbiOut.wssPayload[13:8] == $past(copyControlPayloadMid[5:0]))  // see [R1]
    else $error("wide-screen payload fed from config tail");

  write_read_c: cover property (regWr ##1 regRd);
  ntsc_both_fields_c: cover property (vbiOut.oddFieldEnable && vbiOut.evenFieldEnable);
  pal_wide_screen_c: cover property (vbiOut.wideScreenEnable);
  hue_and_pedestal_c: cover property (pictureOut.huePhase != 8'sh00 && pictureOut.pedestal == 5'h12);

endmodule : vbr_regs

// File: logic/vbr_pkg.sv
// shared constants and carrier types for the vbi payload and picture adjust register group
package vbr_pkg;

  // register subaddresses
  localparam logic [7:0] ADDR_COPY_CONFIG  = 8'h19;
  localparam logic [7:0] ADDR_PAYLOAD_MID  = 8'h1A;
  localparam logic [7:0] ADDR_PAYLOAD_LOW  = 8'h1B;
  localparam logic [7:0] ADDR_CONTRAST     = 8'h1D;
  localparam logic [7:0] ADDR_U_COLOUR     = 8'h1E;
  localparam logic [7:0] ADDR_V_COLOUR     = 8'h1F;
  localparam logic [7:0] ADDR_HUE          = 8'h20;
  localparam logic [7:0] ADDR_BRIGHTNESS   = 8'h21;
  localparam logic [7:0] ADDR_SHARPNESS    = 8'h22;

  // reset values and the unmapped read value
  localparam logic [7:0] RST_COPY_CONFIG   = 8'h00;
  localparam logic [7:0] RST_PAYLOAD_MID   = 8'h00;
  localparam logic [7:0] RST_PAYLOAD_LOW   = 8'h00;
  localparam logic [7:0] RST_SCALE         = 8'h20;
  localparam logic [7:0] RST_HUE           = 8'h80;
  localparam logic [7:0] RST_BRIGHTNESS    = 8'h00;
  localparam logic [7:0] RST_SHARPNESS     = 8'h06;
  localparam logic [7:0] RST_READ_DATA     = 8'h00;
  localparam logic [7:0] UNMAPPED_READ     = 8'h00;

  // copy_control_config field positions and the top shared bit of the middle register
  localparam int CFG_TAIL_MSB       = 3;
  localparam int CFG_CHECKSUM_AUTO  = 4;
  localparam int CFG_ODD_FIELD      = 5;
  localparam int CFG_EVEN_FIELD     = 6;
  localparam int CFG_WIDE_SCREEN    = 7;
  localparam int SHARED_MID_MSB     = 5;

  // picture adjust field limits and codings, checksum preset and data length
  localparam logic [7:0] GAIN_BASE         = 8'h60;
  localparam logic [7:0] HUE_CENTRE        = 8'h80;
  localparam logic [4:0] PEDESTAL_MAX      = 5'h12;
  localparam logic [3:0] SHARPNESS_MAX     = 4'hC;
  localparam logic [5:0] CRC_PRESET        = 6'h3F;
  localparam int         CRC_DATA_BITS     = 14;

  typedef struct packed {
    logic [19:0] cgmsPayload;
    logic        oddFieldEnable;
    logic        evenFieldEnable;
    logic        wideScreenEnable;
    logic [13:0] wssPayload;
  } vbr_vbi_s;

  typedef struct packed {
    logic [7:0]        lumaGain;
    logic [7:0]        uGain;
    logic [7:0]        vGain;
    logic signed [7:0] huePhase;
    logic [4:0]        pedestal;
    logic [3:0]        sharpness;
  } vbr_picture_s;

endpackage : vbr_pkg

// File: logic/vbr_crc_gen.sv
// copy-generation payload finisher: optional six-bit checksum over the low fourteen bits
module vbr_crc_gen (
  input  wire logic        ref_clk,     // pixel clock
  input  wire logic        rstn,        // synchronised reset, active low
  input  wire logic [19:0] rawPayload,  // payload as held in the registers, bit n is Cn
  input  wire logic        autoCrc,     // checksum computed here when high
  output logic      [19:0] payload      // finished payload, registered
);

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  // serial form of x^6 + x + 1, C0 shifted in first
  function automatic logic [5:0] crc6(input logic [13:0] data);
    logic [5:0] crc;
    logic       fb;
    crc = vbr_pkg::CRC_PRESET;
    fb  = 1'b0;
    for (int i = 0; i < vbr_pkg::CRC_DATA_BITS; i++) begin
      fb  = data[i] ^ crc[5];
      crc = {crc[4:0], fb} ^ {4'h0, fb, 1'b0};
    end
    return crc;
  endfunction : crc6

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      payload <= 20'h00000;
    end else if (autoCrc) begin
      payload <= {crc6(rawPayload[13:0]), rawPayload[13:0]};  // see [R2]
    end else begin
      payload <= rawPayload;  // see [R2]
    end
  end

  manual_crc_pass_a: assert property (!autoCrc |=> payload == $past(rawPayload))  // see [R2]
    else $error("register checksum not passed unchanged");
  auto_crc_value_a: assert property (autoCrc |=> payload[19:14] == crc6($past(rawPayload[13:0])))  // see [R2]
    else $error("computed checksum wrong");
  data_kept_a: assert property (1'b1 |=> payload[13:0] == $past(rawPayload[13:0]))  // see [R2]
    else $error("payload data bits altered");

  auto_crc_c: cover property (autoCrc ##1 !autoCrc);

endmodule : vbr_crc_gen

// File: sim/vbr_host_model.sv
// host processor model that drives the register strobes of the vbi and picture adjust group
module vbr_host_model (
  input  wire logic       ref_clk,   // pixel clock
  output logic      [7:0] regAddr,   // register subaddress
  output logic      [7:0] regWrData, // write data
  output logic            regWr,     // write strobe
  output logic            regRd      // read strobe
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    regAddr   = 8'h00;
    regWrData = 8'h00;
    regWr     = 1'b0;
    regRd     = 1'b0;
  end

  // reserved bits of the picture adjust registers always go out as zero
  function automatic logic [7:0] clean(input logic [7:0] a, input logic [7:0] d);
    case (a)
      vbr_pkg::ADDR_CONTRAST, vbr_pkg::ADDR_U_COLOUR, vbr_pkg::ADDR_V_COLOUR: return d & 8'h3F;
      vbr_pkg::ADDR_BRIGHTNESS: return d & 8'h1F;
      vbr_pkg::ADDR_SHARPNESS:  return d & 8'h0F;
      default:                  return d;
    endcase
  endfunction : clean

  // called at a falling edge; strobe stays up so back-to-back requests need no gap
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    regAddr   = a;
    regWrData = clean(a, d);
    regRd     = 1'b0;
    regWr     = 1'b1;
    @(negedge ref_clk);
  endtask : write

  task automatic read(input logic [7:0] a);
    regAddr = a;
    regWr   = 1'b0;
    regRd   = 1'b1;
    @(negedge ref_clk);
  endtask : read

  // released lines show the inverse so a stale value is never mistaken for a held one
  task automatic idle();
    regWr     = 1'b0;
    regRd     = 1'b0;
    regAddr   = ~regAddr;
    regWrData = ~regWrData;
  endtask : idle
endmodule : vbr_host_model

// File: sim/tb_top.sv
// self-checking bench for the vbi payload and picture adjust registers
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  logic                  ref_clk;
  logic                  rstn;
  logic [7:0]            regAddr;
  logic [7:0]            regWrData;
  logic                  regWr;
  logic                  regRd;
  logic [7:0]            regRdData;
  logic                  palMode;
  logic                  hueAdjustEnable;
  logic                  brightnessEnable;
  vbr_pkg::vbr_vbi_s     vbiOut;
  vbr_pkg::vbr_picture_s pictureOut;
  logic                  rdDone;
  logic [7:0]            expQ[$];
  int                    nErrors;
  int                    samplesChecked;
  int                    seed;
  logic [7:0]            addrs[9] = '{8'h19, 8'h1A, 8'h1B, 8'h1D, 8'h1E, 8'h1F, 8'h20, 8'h21, 8'h22};
  logic [7:0]            rstv[9]  = '{8'h00, 8'h00, 8'h00, 8'h20, 8'h20, 8'h20, 8'h80, 8'h00, 8'h06};
  logic [7:0]            msk[9]   = '{8'hFF, 8'hFF, 8'hFF, 8'h3F, 8'h3F, 8'h3F, 8'hFF, 8'h1F, 8'h0F};
  logic [7:0]            gc[3]    = '{8'h00, 8'h13, 8'h3F};
  logic [7:0]            hc[3]    = '{8'h00, 8'h80, 8'hFF};
  logic [7:0]            bc[3]    = '{8'h00, 8'h12, 8'h13};
  logic [7:0]            sc[3]    = '{8'h00, 8'h06, 8'h0C};
  logic [7:0]            cfg;
  logic [7:0]            mid;
  logic [7:0]            low;

  vbr_regs uut (.ref_clk(ref_clk), .rstn(rstn), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData), .palMode(palMode), .hueAdjustEnable(hueAdjustEnable),
    .brightnessEnable(brightnessEnable), .vbiOut(vbiOut), .pictureOut(pictureOut));

  vbr_host_model host (.ref_clk(ref_clk), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      nErrors++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    expQ.push_back(exp);
    host.read(a);
  endtask : rd

  // checksum over C0..C13, first bit shifted first, result lands in C14..C19
  function automatic logic [5:0] crcOf(input logic [13:0] d);
    logic [5:0] c;
    logic       fb;
    c = 6'h3F;
    for (int i = 0; i < 14; i++) begin
      fb = d[i] ^ c[5];
      c  = {c[4:0], fb} ^ {4'h0, fb, 1'b0};
    end
    return c;
  endfunction : crcOf

  task automatic reportAndStop();
    $display("checks=%0d mismatches=%0d", samplesChecked, nErrors);
    if (nErrors == 0 && samplesChecked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : reportAndStop

  // read data is registered, so it is judged at the falling edge after the strobe edge
  always @(posedge ref_clk) rdDone <= regRd;
  always @(negedge ref_clk) begin
    if (rdDone === 1'b1 && expQ.size() > 0) chk({24'h0, regRdData}, {24'h0, expQ.pop_front()});
  end

  initial begin
    #(50 * 20000);
    nErrors++;
    reportAndStop();
  end

  initial begin
    seed = 32'h0519;
    rstn = 1'b0;
    rdDone = 1'b0;
    palMode = 1'b0;
    hueAdjustEnable = 1'b0;
    brightnessEnable = 1'b0;
    repeat (2) @(negedge ref_clk);
    rstn = 1'b1;
    repeat (3) @(negedge ref_clk);
    chk({24'h0, pictureOut.lumaGain}, 32'h80);
    chk({28'h0, pictureOut.sharpness}, 32'h6);
    for (int i = 0; i < 9; i++) rd(addrs[i], rstv[i]);
    host.idle();
    $display("test reset values done");
    for (int i = 0; i < 9; i++) begin
      low = $random(seed) & msk[i];
      host.write(addrs[i], low);
      rd(addrs[i], low);
    end
    host.write(8'h1C, 8'hA5);
    rd(8'h1C, 8'h00);
    host.idle();
    $display("test readback done");
    for (int i = 0; i < 3; i++) begin
      host.write(vbr_pkg::ADDR_CONTRAST, gc[i]);
      host.write(vbr_pkg::ADDR_U_COLOUR, gc[2 - i]);
      host.write(vbr_pkg::ADDR_V_COLOUR, gc[i]);
      host.write(vbr_pkg::ADDR_HUE, hc[i]);
      host.write(vbr_pkg::ADDR_BRIGHTNESS, bc[i]);
      host.write(vbr_pkg::ADDR_SHARPNESS, sc[i]);
      host.idle();
      palMode = i[0];
      hueAdjustEnable = 1'b1;
      brightnessEnable = 1'b1;
      @(negedge ref_clk);
      chk({24'h0, pictureOut.lumaGain}, 32'h60 + gc[i]);
      chk({24'h0, pictureOut.uGain}, 32'h60 + gc[2 - i]);
      chk({24'h0, pictureOut.vGain}, 32'h60 + gc[i]);
      chk({24'h0, pictureOut.huePhase}, {24'h0, hc[i] ^ 8'h80});
      chk({27'h0, pictureOut.pedestal}, (bc[i] > 8'h12) ? 32'h12 : {24'h0, bc[i]});
      chk({28'h0, pictureOut.sharpness}, {24'h0, sc[i]});
      hueAdjustEnable = 1'b0;
      brightnessEnable = 1'b0;
      @(negedge ref_clk);
      chk({24'h0, pictureOut.huePhase}, 32'h0);
      chk({27'h0, pictureOut.pedestal}, 32'h0);
    end
    $display("test picture adjust done");
    for (int j = 0; j < 4; j++) begin
      cfg = $random(seed);
      cfg[4] = j[1];
      mid = $random(seed);
      low = $random(seed);
      palMode = j[0];
      host.write(vbr_pkg::ADDR_COPY_CONFIG, cfg);
      host.write(vbr_pkg::ADDR_PAYLOAD_MID, mid);
      host.write(vbr_pkg::ADDR_PAYLOAD_LOW, low);
      host.idle();
      @(negedge ref_clk);
      chk({18'h0, vbiOut.cgmsPayload[13:0]}, {18'h0, mid[5:0], low});
      chk({30'h0, vbiOut.cgmsPayload[15:14]}, j[1] ? {26'h0, crcOf({mid[5:0], low})} >> 0 & 32'h3 :
        {30'h0, mid[7:6]});
      chk({26'h0, vbiOut.cgmsPayload[19:14]}, j[1] ? {26'h0, crcOf({mid[5:0], low})} :
        {26'h0, cfg[3:0], mid[7:6]});
      chk({18'h0, vbiOut.wssPayload}, {18'h0, mid[5:0], low});
      chk({29'h0, vbiOut.oddFieldEnable, vbiOut.evenFieldEnable, vbiOut.wideScreenEnable},
        {29'h0, cfg[5] & ~j[0], cfg[6] & ~j[0], cfg[7] & j[0]});
    end
    $display("test copy and wide-screen payload done");
    repeat (2) @(negedge ref_clk);
    chk(expQ.size(), 32'h0);
    reportAndStop();
  end
endmodule : tb_top
